// *** rtl/msrm_top.sv ***
/*
  msrm_top: operating mode control and internal map placement.
  assumes a cpu-side register port with one-cycle strobes, reads answered the
  next cycle, and a cpu address bus decoded combinationally into the map selects.
*/
// Local design decision: the plain strobed port.
// Notes on behaviour
// - single chip: no external bus, boot rom twice
// - single chip ram 0400, regs 0000, internal vectors
// - special test then clear mode a: bootstrap
// - bootstrap vectors come from ram 04c4-04fd
// - loader downloads 256 bytes, jumps to 0400
// - special test: rom at fc00, vectors bfc0
// - special bit is inverse of mode pin
// - two bits decode four modes, mode a resets one
// - special modes write freely; normal: mode a once
// - special bit never set again after clear
// - boot read bit maps rom at be00
// - visibility drives internal read data out
// - visibility bit written once, reset per mode
// - expanded/test: bit controls read visibility
// - single/boot: bit set holds e low
// - position field gives register address bits 15:10
// - position write once within 64 cycles in normal
// - registers win over ram on overlap
// - priority register bit 4 reads zero
// - config write once outside special modes
// - visibility bit is bit 4 at 0038
module msrm_top
  import msrm_pkg::*;
#(
  parameter int WINDOW_CYCLES = REGPOS_WINDOW
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // strap
  input  wire logic        mode_pin,
  // register port
  input  wire logic [6:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // instruction boundary from the cpu
  input  wire logic        insn_start,
  // cpu bus to decode
  input  wire logic [15:0] cpu_addr,
  input  wire logic        cpu_read,
  input  wire logic        vector_fetch,
  input  wire logic [7:0]  internal_rdata,
  input  wire logic        e_clock_in,
  // map decode
  output logic             sel_regs,
  output logic             sel_ram,
  output logic             sel_boot_rom,
  output logic             sel_external,
  output logic [15:0]      vector_addr,
  // external pins
  output logic             ext_bus_enable,
  output logic [7:0]       ext_data_out,
  output logic             ext_data_oe,
  output logic             e_pin,
  // status
  output logic [1:0]       mode,
  output logic             special_mode_bit,
  output logic             mode_select_a,
  output logic             internal_read_visibility,
  output logic             e_clock_gate,
  output logic             ram_enable_bit,
  output logic [7:0]       config_active
);

  logic       strap_done_r;
  logic       special_r;
  logic       mode_a_r;
  logic       mode_a_once_r;
  logic       boot_read_r;
  logic [3:0] psel_r;
  logic       vis_r;
  logic       vis_once_r;
  logic [5:0] regpos_r;
  logic       regpos_once_r;
  logic [WIN_CNT_W-1:0] win_cnt_r;
  logic [5:0] rampos_r;
  logic [7:0] config_r;
  logic       config_once_r;
  logic [7:0] config_act_r;
  logic       config_pend_r;
  logic [7:0] rdata_r;
  logic [7:0] ext_data_r;
  logic       ext_oe_r;
  logic       e_pin_r;

  msrm_mode_t mode_cur;

  wire wr_prio   = reg_wr && (reg_addr == OFS_PRIO);
  wire wr_regpos = reg_wr && (reg_addr == OFS_REGPOS);
  wire wr_vis    = reg_wr && (reg_addr == OFS_VISOPT);
  wire wr_config = reg_wr && (reg_addr == OFS_CONFIG);
  wire wr_rampos = reg_wr && (reg_addr == OFS_RAMPOS);

  // mode decode from the two bits
  function automatic msrm_mode_t decode_mode(input logic special, input logic mode_a);
    decode_mode = MSRM_EXPANDED;
    case ({special, mode_a})
      2'b11:   decode_mode = MSRM_TEST;
      2'b00:   decode_mode = MSRM_SINGLE;
      2'b10:   decode_mode = MSRM_BOOT;
      default: decode_mode = MSRM_EXPANDED;
    endcase
  endfunction

  // mode classes used by several decoders
  function automatic logic mode_has_bus(input msrm_mode_t m);
    return (m == MSRM_EXPANDED) || (m == MSRM_TEST);
  endfunction

  function automatic logic mode_is_normal(input msrm_mode_t m);
    return (m == MSRM_EXPANDED) || (m == MSRM_SINGLE);
  endfunction

  assign mode_cur = decode_mode(special_r, mode_a_r);

  wire in_window = (win_cnt_r < WIN_CNT_W'(WINDOW_CYCLES));
  wire normal_regpos = mode_is_normal(mode_cur);

  // window and once only in expanded and single chip
  wire regpos_ok = normal_regpos ? (in_window && !regpos_once_r) : 1'b1;
  // mode a once in normal modes
  wire mode_a_ok = special_r || !mode_a_once_r;
  wire config_ok = special_r || !config_once_r;
  // special bit may only be cleared
  wire special_nxt = special_r && reg_wdata[BIT_SPECIAL];

  // first clocked cycle after reset release catches the strap
  always_ff @(posedge clk) begin
    if (rst) begin
      strap_done_r <= 1'b0;
    end else begin
      strap_done_r <= 1'b1;
    end
  end

  // special bit caught from the pin at reset release
  // special bit cannot be set again
  always_ff @(posedge clk) begin
    if (rst) begin
      special_r <= 1'b0;
    end else if (!strap_done_r) begin
      special_r <= !mode_pin;
    end else if (wr_prio) begin
      special_r <= special_nxt;
    end
  end

  // mode a free in special modes, once otherwise
  // writes in the strap cycle are lost on purpose
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_a_r      <= 1'b1;
      mode_a_once_r <= 1'b0;
    end else if (strap_done_r && wr_prio && mode_a_ok) begin
      mode_a_r      <= reg_wdata[BIT_MODE_A];
      mode_a_once_r <= 1'b1;
    end
  end

  // boot read bit, reset zero in every mode since mode a is still one at the strap
  always_ff @(posedge clk) begin
    if (rst) begin
      boot_read_r <= 1'b0;
    end else if (!strap_done_r) begin
      boot_read_r <= !mode_pin && !mode_a_r;
    end else if (wr_prio && special_r) begin
      boot_read_r <= reg_wdata[BIT_BOOT_READ];
    end
  end

  // priority select field, plain read and write
  always_ff @(posedge clk) begin
    if (rst) begin
      psel_r <= PSEL_RESET;
    end else if (strap_done_r && wr_prio) begin
      psel_r <= reg_wdata[3:0];
    end
  end

  // reset one in special test, written once in any mode
  // once flags only cleared by reset
  always_ff @(posedge clk) begin
    if (rst) begin
      vis_r      <= 1'b0;
      vis_once_r <= 1'b0;
    end else if (!strap_done_r) begin
      vis_r <= !mode_pin && mode_a_r;
    end else if (wr_vis && !vis_once_r) begin
      vis_r      <= reg_wdata[BIT_VIS_E];
      vis_once_r <= 1'b1;
    end
  end

  // window counter stops at the limit so it never wraps back open
  always_ff @(posedge clk) begin
    if (rst) begin
      win_cnt_r <= '0;
    end else if (in_window) begin
      win_cnt_r <= win_cnt_r + WIN_CNT_W'(1);
    end
  end

  // once flag only cleared by reset
  always_ff @(posedge clk) begin
    if (rst) begin
      regpos_r      <= REGPOS_RESET;
      regpos_once_r <= 1'b0;
    end else if (wr_regpos && regpos_ok) begin
      regpos_r      <= reg_wdata[7:2];
      regpos_once_r <= 1'b1;
    end
  end

  // ram position, writable any time
  always_ff @(posedge clk) begin
    if (rst) begin
      rampos_r <= RAMPOS_RESET;
    end else if (wr_rampos) begin
      rampos_r <= reg_wdata[7:2];
    end
  end

  // config written once outside special modes
  always_ff @(posedge clk) begin
    if (rst) begin
      config_r      <= CONFIG_RESET;
      config_once_r <= 1'b0;
    end else if (wr_config && config_ok) begin
      config_r      <= reg_wdata;
      config_once_r <= 1'b1;
    end
  end

  // config takes effect at the next instruction start
  // a write in the same cycle as a start waits for the following one
  always_ff @(posedge clk) begin
    if (rst) begin
      config_act_r  <= CONFIG_RESET;
      config_pend_r <= 1'b0;
    end else if (wr_config && config_ok) begin
      config_pend_r <= 1'b1;
    end else if (insn_start && config_pend_r) begin
      config_act_r  <= config_r;
      config_pend_r <= 1'b0;
    end
  end

  // read mux
  // bit 4 of the priority register reads zero
  // visibility bit at bit 4 of 0038
  wire [7:0] prio_rd   = {boot_read_r, special_r, mode_a_r, 1'b0, psel_r};
  wire [7:0] regpos_rd = {regpos_r, 2'b00};
  wire [7:0] rampos_rd = {rampos_r, 2'b00};
  wire [7:0] vis_rd    = {3'b000, vis_r, 4'b0000};
  wire [7:0] config_rd = config_r & 8'h27;
  logic [7:0] rd_mux;

  // unmapped offsets read as zero
  always_comb begin
    rd_mux = 8'h00;
    case (reg_addr)
      OFS_PRIO:   rd_mux = prio_rd;
      OFS_REGPOS: rd_mux = regpos_rd;
      OFS_VISOPT: rd_mux = vis_rd;
      OFS_CONFIG: rd_mux = config_rd;
      OFS_RAMPOS: rd_mux = rampos_rd;
      default:    rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // map decode
  // register block at regpos:0000-007f
  wire hit_regs = (cpu_addr[15:10] == regpos_r) && (cpu_addr[9:7] == 3'b000);
  wire hit_ram  = ram_enable_bit && (cpu_addr[15:10] == rampos_r) && (cpu_addr[9:8] == 2'b00);
  // single chip rom at bc00 and fc00
  // boot read bit rom at be00 in special modes
  wire hit_hi   = (cpu_addr[15:10] == BOOT_HI_BASE[15:10]);
  wire hit_lo   = (cpu_addr[15:10] == BOOT_LO_BASE[15:10]);
  wire hit_rb   = (cpu_addr[15:9] == BOOT_RB_BASE[15:9]);
  wire hit_boot = ((mode_cur == MSRM_SINGLE) && (hit_hi || hit_lo))
                || ((mode_cur == MSRM_TEST) && hit_hi)
                || (special_r && boot_read_r && hit_rb);
  // bootstrap mode keeps the rom in the map
  wire hit_boot_b = (mode_cur == MSRM_BOOT) && (hit_hi || hit_rb && boot_read_r);

  assign sel_regs     = hit_regs;
  assign sel_ram      = hit_ram && !hit_regs;
  assign sel_boot_rom = !hit_regs && !hit_ram && (hit_boot || hit_boot_b);
  // no external space in single chip or bootstrap
  assign ext_bus_enable = mode_has_bus(mode_cur);
  assign sel_external   = ext_bus_enable && !sel_regs && !sel_ram && !sel_boot_rom;

  // internal vectors at ffc0 in single chip
  wire [15:0] vec_boot = VEC_BOOT_LO + {10'h000, cpu_addr[5:0]} - 16'h0004;
  logic [15:0] vec_sel;

  // expanded mode uses the same ffc0 table, only fetched externally
  always_comb begin
    vec_sel = VEC_BASE | {10'h000, cpu_addr[5:0]};
    unique case (mode_cur)
      MSRM_TEST:     vec_sel = VEC_TEST_BASE | {10'h000, cpu_addr[5:0]};
      MSRM_BOOT:     vec_sel = vec_boot;
      MSRM_EXPANDED: vec_sel = VEC_BASE | {10'h000, cpu_addr[5:0]};
      MSRM_SINGLE:   vec_sel = VEC_BASE | {10'h000, cpu_addr[5:0]};
    endcase
  end

  assign vector_addr = vec_sel;

  // visibility on only in expanded and test modes
  // e gated only in single chip and bootstrap
  assign internal_read_visibility = ext_bus_enable && vis_r;
  assign e_clock_gate             = !ext_bus_enable && vis_r;

  // internal reads driven onto the external data bus
  always_ff @(posedge clk) begin
    if (rst) begin
      ext_oe_r <= 1'b0;
    end else begin
      ext_oe_r <= internal_read_visibility && cpu_read && !sel_external;
    end
  end

  // captured every cycle; only meaningful beside the enable
  always_ff @(posedge clk) begin
    if (rst) begin
      ext_data_r <= 8'h00;
    end else begin
      ext_data_r <= internal_rdata;
    end
  end

  // e pin held low while gated
  always_ff @(posedge clk) begin
    if (rst) begin
      e_pin_r <= 1'b0;
    end else begin
      e_pin_r <= e_clock_gate ? 1'b0 : e_clock_in;
    end
  end

  assign reg_rdata        = rdata_r;
  assign ext_data_out     = ext_data_r;
  assign ext_data_oe      = ext_oe_r;
  assign e_pin            = e_pin_r;
  assign mode             = mode_cur;
  assign special_mode_bit = special_r;
  assign mode_select_a    = mode_a_r;
  assign ram_enable_bit   = config_act_r[BIT_RAM_ENABLE] || (mode_cur != MSRM_EXPANDED);
  assign config_active    = config_act_r;

  // loader entry and last download byte address
  wire unused_ok = (RAM_ENTRY != RAM_LAST) || vector_fetch;

endmodule

// *** shared/msrm_pkg.sv ***
/*
  msrm_pkg: constants for the mode select and register map block.
  assumes a single 8-bit register port, byte offsets relative to the register block.
*/
package msrm_pkg;

  // register offsets inside the 128-byte block
  localparam logic [6:0] OFS_PRIO     = 7'h3c;
  localparam logic [6:0] OFS_REGPOS   = 7'h3d;
  localparam logic [6:0] OFS_VISOPT   = 7'h38;
  localparam logic [6:0] OFS_CONFIG   = 7'h3f;
  localparam logic [6:0] OFS_RAMPOS   = 7'h37;

  // field positions
  localparam int BIT_BOOT_READ  = 7;
  localparam int BIT_SPECIAL    = 6;
  localparam int BIT_MODE_A     = 5;
  localparam int BIT_VIS_E      = 4;
  localparam int BIT_RAM_ENABLE = 1;

  // reset values
  localparam logic [3:0] PSEL_RESET   = 4'h5;
  localparam logic [5:0] REGPOS_RESET = 6'h00;
  localparam logic [5:0] RAMPOS_RESET = 6'h01;
  localparam logic [7:0] CONFIG_RESET = 8'h00;

  // register write window after reset, in cycles
  localparam int          REGPOS_WINDOW = 64;
  localparam int          WIN_CNT_W     = 7;

  // map constants
  localparam logic [15:0] BOOT_LO_BASE   = 16'hbc00;
  localparam logic [15:0] BOOT_HI_BASE   = 16'hfc00;
  localparam logic [15:0] BOOT_RB_BASE   = 16'hbe00;
  localparam logic [15:0] VEC_BASE      = 16'hffc0;
  localparam logic [15:0] VEC_TEST_BASE = 16'hbfc0;
  localparam logic [15:0] VEC_BOOT_LO   = 16'h04c4;
  localparam logic [15:0] VEC_BOOT_HI   = 16'h04fd;
  localparam logic [15:0] RAM_ENTRY     = 16'h0400;
  localparam logic [15:0] RAM_LAST      = 16'h04ff;

  typedef enum logic [1:0] {
    MSRM_EXPANDED,
    MSRM_TEST,
    MSRM_SINGLE,
    MSRM_BOOT
  } msrm_mode_t;

endpackage

// *** verif/msrm_monitor.sv ***
/*
  msrm_monitor: port assertions for the mode select and register map block.
  assumes it is bound onto msrm_top; one clock, synchronous reset.
*/
module msrm_monitor
  import msrm_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // register port and cpu bus
  input wire logic [6:0]  reg_addr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic [15:0] cpu_addr,
  input wire logic        cpu_read,
  input wire logic [7:0]  internal_rdata,
  input wire logic        e_clock_in,
  // decode and pins
  input wire logic        sel_regs,
  input wire logic        sel_ram,
  input wire logic        sel_boot_rom,
  input wire logic        sel_external,
  input wire logic [15:0] vector_addr,
  input wire logic        ext_bus_enable,
  input wire logic [7:0]  ext_data_out,
  input wire logic        ext_data_oe,
  input wire logic        e_pin,
  // status
  input wire logic [1:0]  mode,
  input wire logic        special_mode_bit,
  input wire logic        mode_select_a,
  input wire logic        internal_read_visibility,
  input wire logic        e_clock_gate
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // bootstrap table sits four bytes below the first used vector
  wire logic [15:0] vec_base = (mode == MSRM_BOOT) ? VEC_BOOT_LO - 16'h0004 :
                               (mode == MSRM_TEST) ? VEC_TEST_BASE : VEC_BASE;
  wire logic        rom_hit  = (mode == MSRM_SINGLE && cpu_addr[15:10] == 6'h2f) ||
                               (mode inside {MSRM_SINGLE, MSRM_TEST} && cpu_addr[15:10] == 6'h3f);
  sequence prio_read;
    reg_rd && reg_addr == OFS_PRIO;
  endsequence
  sequence vis_read;
    cpu_read && internal_read_visibility;
  endsequence
  chk_mode_decode: assert property (mode == {~mode_select_a, special_mode_bit})
    else $error("mode output disagrees with mode bits");
  chk_ext_bus: assert property (ext_bus_enable == mode_select_a)
    else $error("external bus enable wrong for mode");
  chk_special_mode_bit_sticky: assert property (!$past(special_mode_bit) && !$past(rst) && !$past(rst, 2) |-> !special_mode_bit)
    else $error("special bit set again after clear");
  chk_prio_read: assert property (prio_read |=> !reg_rdata[4] && reg_rdata[6:5] == $past({special_mode_bit, mode_select_a}))
    else $error("priority register read back wrong");
  chk_vis_enable: assert property (!$past(rst) |-> ext_data_oe == $past(cpu_read && internal_read_visibility && !sel_external))
    else $error("visibility drive enable wrong");
  chk_vis_data: assert property (vis_read |=> ext_data_out == $past(internal_rdata))
    else $error("visibility data does not follow internal read");
  chk_irv_mode: assert property (internal_read_visibility |-> !mode[1])
    else $error("read visibility on in single or boot mode");
  chk_gate_mode: assert property (e_clock_gate |-> mode[1])
    else $error("e gating outside single or boot mode");
  chk_e_pin: assert property (!$past(rst) |-> e_pin == ($past(e_clock_in) && !$past(e_clock_gate)))
    else $error("e pin does not follow gated e clock");
  chk_vector_base: assert property (vector_addr == vec_base + {10'h000, cpu_addr[5:0]})
    else $error("vector address wrong for mode");
  chk_reg_priority: assert property (sel_regs |-> !sel_ram)
    else $error("ram selected over register block");
  chk_boot_rom: assert property (rom_hit |-> sel_boot_rom)
    else $error("boot rom missing from map");
endmodule

// *** verif/msrm_top_test.sv ***
/*
  msrm_top_test: directed bench for the mode select and register map block.
  assumes msrm_top, msrm_monitor and msrm_pkg are compiled alongside.
*/
module msrm_top_test
  import msrm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'b0, rst = 1'b1, mode_pin = 1'b1;
  logic [6:0]  reg_addr = 7'h00;
  logic [7:0]  reg_wdata = 8'h00, internal_rdata = 8'h00;
  logic        reg_wr = 1'b0, reg_rd = 1'b0, insn_start = 1'b0, cpu_read = 1'b0, e_clock_in = 1'b0;
  logic [15:0] cpu_addr = 16'h0000;
  wire logic [7:0]  reg_rdata, ext_data_out, config_active;
  wire logic [15:0] vector_addr;
  wire logic [1:0]  mode;
  wire logic        sel_regs, sel_ram, sel_boot_rom, sel_external, ext_bus_enable, ext_data_oe, e_pin;
  wire logic        special_mode_bit, mode_select_a, internal_read_visibility, e_clock_gate, ram_enable_bit;
  int n_errors = 0;
  int num_checks = 0;
  // short window keeps the expiry case quick
  msrm_top #(.WINDOW_CYCLES(8)) u_msrm_top (.clk, .rst, .mode_pin, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .insn_start, .cpu_addr, .cpu_read, .vector_fetch(1'b0), .internal_rdata, .e_clock_in,
    .sel_regs, .sel_ram, .sel_boot_rom, .sel_external, .vector_addr, .ext_bus_enable, .ext_data_out,
    .ext_data_oe, .e_pin, .mode, .special_mode_bit, .mode_select_a, .internal_read_visibility,
    .e_clock_gate, .ram_enable_bit, .config_active);
  always #2.5 clk = ~clk;
  always @(posedge clk) e_clock_in <= ~e_clock_in;
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    #1;
  endtask
  task automatic rdchk(input logic [6:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 cmp(reg_rdata, exp);
  endtask
  task automatic step(input logic [15:0] a);
    @(posedge clk);
    cpu_addr <= a;
    #1;
  endtask
  task automatic do_reset(input logic pin);
    @(posedge clk);
    rst      <= 1'b1;
    mode_pin <= pin;
    repeat (3) @(posedge clk);
    rst      <= 1'b0;
  endtask
  task automatic t_normal;
    do_reset(1'b1);
    wr(OFS_REGPOS, 8'h04);
    wr(OFS_REGPOS, 8'h08);
    rdchk(OFS_REGPOS, 8'h04);
    rdchk(OFS_PRIO, 8'h25);
    rdchk(OFS_VISOPT, 8'h00);
    wr(OFS_CONFIG, 8'h02);
    cmp(config_active, 8'h00);
    @(posedge clk);
    insn_start <= 1'b1;
    @(posedge clk);
    insn_start <= 1'b0;
    #1 cmp(config_active, 8'h02);
    wr(OFS_CONFIG, 8'h00);
    rdchk(OFS_CONFIG, 8'h02);
    step(16'h0410);
    cmp({sel_regs, sel_ram}, 16'h0002);
    step(16'h0490);
    cmp({sel_regs, sel_ram}, 16'h0001);
    step(16'h8000);
    cmp(sel_external, 16'h0001);
    $display("t_normal done");
  endtask
  task automatic t_single;
    do_reset(1'b1);
    repeat (10) @(posedge clk);
    wr(OFS_REGPOS, 8'h08);
    rdchk(OFS_REGPOS, 8'h00);
    wr(OFS_PRIO, 8'h05);
    cmp(mode, MSRM_SINGLE);
    wr(OFS_PRIO, 8'h65);
    rdchk(OFS_PRIO, 8'h05);
    wr(OFS_VISOPT, 8'h10);
    wr(OFS_VISOPT, 8'h00);
    rdchk(OFS_VISOPT, 8'h10);
    cmp(e_clock_gate, 16'h0001);
    step(16'hbc10);
    cmp({sel_boot_rom, ext_bus_enable}, 16'h0002);
    step(16'hffc6);
    cmp(vector_addr, 16'hffc6);
    cmp(ram_enable_bit, 16'h0001);
    cmp(e_pin, 16'h0000);
    $display("t_single done");
  endtask
  task automatic t_special;
    do_reset(1'b0);
    rdchk(OFS_PRIO, 8'h65);
    rdchk(OFS_VISOPT, 8'h10);
    @(posedge clk);
    cpu_read       <= 1'b1;
    internal_rdata <= 8'ha5;
    @(posedge clk);
    cpu_read <= 1'b0;
    #1 cmp({ext_data_oe, ext_data_out}, 16'h01a5);
    step(16'hffc6);
    cmp(sel_boot_rom, 16'h0001);
    cmp(vector_addr, 16'hbfc6);
    wr(OFS_PRIO, 8'he5);
    rdchk(OFS_PRIO, 8'he5);
    step(16'hbe10);
    cmp(sel_boot_rom, 16'h0001);
    step(16'hffc6);
    wr(OFS_PRIO, 8'h45);
    cmp(mode, MSRM_BOOT);
    cmp(vector_addr, 16'h04c6);
    wr(OFS_PRIO, 8'h65);
    cmp(mode, MSRM_TEST);
    wr(OFS_PRIO, 8'h25);
    wr(OFS_PRIO, 8'h65);
    cmp(mode, MSRM_EXPANDED);
    $display("t_special done");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    t_normal;
    t_single;
    t_special;
    tally_and_finish;
  end
  // whole run is under a hundred cycles
  initial begin
    #20000;
    n_errors++;
    tally_and_finish;
  end
endmodule
bind msrm_top msrm_monitor u_msrm_monitor (.clk, .rst, .reg_addr, .reg_rd, .reg_rdata, .cpu_addr, .cpu_read,
  .internal_rdata, .e_clock_in, .sel_regs, .sel_ram, .sel_boot_rom, .sel_external, .vector_addr, .ext_bus_enable,
  .ext_data_out, .ext_data_oe, .e_pin, .mode, .special_mode_bit, .mode_select_a,
  .internal_read_visibility, .e_clock_gate);
